/* rtl/rscl_latch.sv */
// reset-time strap configuration latch with wishbone register access
//
// Functional notes
// - latch straps on edge before reset release
// - eight data bus lines carry the straps
// - no override circuit needed; defaults apply
// - pin values used only with override enable
// - bit1 clock ratio, bit6 limp mode
// - bit2 oscillator bypass, bit7 reference frequency
// - bits 4:3 select boot port width
// - bit5 selects output pad drive strength
// - bit9 selects address or chip-select pins
// - remaining data bits never affect configuration
// - data pins stay inputs until one clock after
// - memory strap low forbids 32-bit boot width
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps

module rscl_latch
    import rscl_pkg::*;
#(
    parameter int HOLD_CYCLES = rscl_pkg::RSCL_RESET_OUTPUT_HOLD_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    // wishbone classic slave
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [rscl_pkg::RSCL_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [rscl_pkg::RSCL_DATA_W-1:0]  wb_dat_i,
    output logic      [rscl_pkg::RSCL_DATA_W-1:0]  wb_dat_o,
    output logic                                   wb_ack_o,
    // strap pins
    input  wire logic [rscl_pkg::RSCL_DATA_W-1:0]  data_pin_i,
    input  wire logic                              strap_override_enable,
    input  wire logic                              dynamic_memory_select_strap,
    // reset output and pin turnaround
    output logic                                   reset_output_b,
    output logic                                   data_drive_permit,
    // applied configuration
    output logic                                   clock_ratio_high,
    output logic                                   osc_bypass,
    output logic      [1:0]                        boot_width,
    output logic                                   high_drive,
    output logic                                   limp_mode,
    output logic                                   ref_freq_high,
    output logic                                   upper_chip_selects_en
);

    import rscl_pkg::*;

    // ==================================================
    // local sizes
    localparam int CNT_W = $clog2(HOLD_CYCLES + 1) + 1;   // hold/turn counter width
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(RSCL_PIN_TURN_CYC - 1);
    localparam int SYNC_W = RSCL_CFG_W + 2;                // straps plus two pins

    // ==================================================
    // sequence states
    typedef enum logic [1:0] {
        ST_HOLD,        // reset output asserted, pins are inputs
        ST_TURN,        // reset released, pins still inputs
        ST_RUN          // normal operation
    } rscl_state_t;

    // all block state
    typedef struct packed {
        rscl_state_t              st;         // sequence state
        logic [CNT_W-1:0]         cnt;        // cycles in hold or turn state, held at zero in run
        logic                     rst_out_b;  // reset output, active low
        logic                     permit;     // data pins may turn to outputs
        logic [RSCL_CFG_W-1:0]    cfg;        // applied configuration image
        logic [RSCL_CFG_W-1:0]    raw;        // strap pins as seen at capture
        logic                     ovr_used;   // capture took pin values
        logic                     dram;       // memory select strap at capture
        logic                     cap_done;   // sticky capture flag
        logic                     force_def;  // software: next capture uses defaults
        logic                     restart;    // software: rerun reset sequence
        logic                     ack;        // wishbone acknowledge
        logic [RSCL_DATA_W-1:0]   rdata;      // wishbone read data
    } rscl_latch_t;

    rscl_latch_t s_reg;                       // registered state
    rscl_latch_t s_next;                      // next state

    // ==================================================
    // pin synchronisers
    logic [SYNC_W-1:0] pin_async;             // raw pins in
    logic [SYNC_W-1:0] pin_sync;              // pins after two flops
    logic [RSCL_CFG_W-1:0] strap_sync;        // strap lines 9:0
    logic              ovr_en_sync;           // override enable, synchronised
    logic              dram_sync;             // memory strap, synchronised

    // only lines 9:0 are ever looked at; upper lines carry no straps
    assign pin_async = {dynamic_memory_select_strap, strap_override_enable,
                        data_pin_i[RSCL_CFG_W-1:0]};

    rscl_sync #(
        .WIDTH    (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (pin_async),
        .sync_out (pin_sync)
    );

    assign strap_sync  = pin_sync[RSCL_CFG_W-1:0];
    assign ovr_en_sync = pin_sync[RSCL_CFG_W];
    assign dram_sync   = pin_sync[RSCL_CFG_W+1];

    // ==================================================
    // configuration forming
    // pick pin values or defaults field by field
    function automatic logic [RSCL_CFG_W-1:0] form_cfg(
        input logic [RSCL_CFG_W-1:0] pins,
        input logic                  use_pins
    );
        logic [RSCL_CFG_W-1:0] img;
        img = RSCL_CFG_DEFAULT;
        if (use_pins)
        begin
            img = (pins & RSCL_STRAP_MASK) | (RSCL_CFG_DEFAULT & ~RSCL_STRAP_MASK);
        end
        return img;
    endfunction

    // decode boot port width from the two strap bits
    function automatic logic [1:0] decode_boot(
        input logic [1:0] code,
        input logic       dram
    );
        logic [1:0] bw;
        bw = RSCL_BW_32;
        case (code)
            2'h1:    bw = RSCL_BW_16;
            2'h2:    bw = RSCL_BW_8;
            default: bw = RSCL_BW_32;     // 00 and 11 both mean 32-bit
        endcase
        if (!dram && bw == RSCL_BW_32)
        begin
            bw = RSCL_BW_16;
        end
        return bw;
    endfunction

    // ==================================================
    // wishbone decode
    logic wb_req;                             // new request this cycle
    logic wb_wr;                              // write request
    logic [RSCL_DATA_W-1:0] rd_mux;           // read value by address
    logic [1:0] boot_dec;                     // decoded boot width

    // one-cycle answer: ack rises the edge after the request
    assign wb_req   = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign wb_wr    = wb_req && wb_we_i;
    assign boot_dec = decode_boot(s_reg.cfg[RSCL_POS_BOOT_HI:RSCL_POS_BOOT_LO], s_reg.dram);

    // read multiplexer, unmapped offsets read zero
    always_comb
    begin
        rd_mux = '0;
        case (wb_adr_i)
            RSCL_REG_CTRL:
            begin
                rd_mux[RSCL_CTRL_FORCE_DEF] = s_reg.force_def;
            end
            RSCL_REG_STATUS:
            begin
                rd_mux[RSCL_ST_RST_OUT]  = !s_reg.rst_out_b;
                rd_mux[RSCL_ST_PERMIT]   = s_reg.permit;
                rd_mux[RSCL_ST_OVR_USED] = s_reg.ovr_used;
                rd_mux[RSCL_ST_DRAM]     = s_reg.dram;
                rd_mux[RSCL_ST_CAP_DONE] = s_reg.cap_done;
                rd_mux[RSCL_ST_BOOT_LO+1:RSCL_ST_BOOT_LO] = boot_dec;
            end
            RSCL_REG_CONFIG:
            begin
                rd_mux[RSCL_CFG_W-1:0] = s_reg.cfg;
            end
            RSCL_REG_RAW:
            begin
                rd_mux[RSCL_CFG_W-1:0] = s_reg.raw;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    // ==================================================
    // next state
    always_comb
    begin
        s_next         = s_reg;
        s_next.ack     = wb_req;
        s_next.rdata   = wb_req ? rd_mux : s_reg.rdata;

        // software register writes, low byte lane only
        if (wb_wr && wb_sel_i[0])
        begin
            if (wb_adr_i == RSCL_REG_CTRL)
            begin
                s_next.force_def = wb_dat_i[RSCL_CTRL_FORCE_DEF];
                s_next.restart   = wb_dat_i[RSCL_CTRL_RESTART];
            end
            // write one clears the capture flag
            if (wb_adr_i == RSCL_REG_STATUS && wb_dat_i[RSCL_ST_CAP_DONE])
            begin
                s_next.cap_done = 1'b0;
            end
        end

        // reset sequence
        case (s_reg.st)
            ST_HOLD:
            begin
                s_next.permit    = 1'b0;
                s_next.rst_out_b = 1'b0;
                s_next.cnt       = s_reg.cnt + 1'b1;
                if (s_reg.cnt >= HOLD_LAST)
                begin
                    s_next.cfg       = form_cfg(strap_sync, ovr_en_sync && !s_reg.force_def);
                    s_next.raw       = strap_sync & RSCL_STRAP_MASK;
                    s_next.ovr_used  = ovr_en_sync && !s_reg.force_def;
                    s_next.dram      = dram_sync;
                    s_next.cap_done  = 1'b1;    // set wins over a clear
                    s_next.rst_out_b = 1'b1;
                    s_next.cnt       = '0;
                    s_next.st        = ST_TURN;
                end
            end
            ST_TURN:
            begin
                // wait one bus clock before driving
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt >= TURN_LAST)
                begin
                    s_next.permit = 1'b1;
                    s_next.cnt    = '0;
                    s_next.st     = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // software restart reasserts reset and recaptures
                if (s_reg.restart)
                begin
                    s_next.restart   = 1'b0;
                    s_next.permit    = 1'b0;
                    s_next.rst_out_b = 1'b0;
                    s_next.cnt       = '0;
                    s_next.st        = ST_HOLD;
                end
            end
            default:
            begin
                s_next.st = ST_HOLD;
            end
        endcase
    end

    // ==================================================
    // state register, synchronous active-low reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_reg           <= '0;
            s_reg.st        <= ST_HOLD;
            s_reg.cfg       <= RSCL_CFG_DEFAULT;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==================================================
    // outputs
    assign wb_ack_o          = s_reg.ack;
    assign wb_dat_o          = s_reg.rdata;
    assign reset_output_b    = s_reg.rst_out_b;
    assign data_drive_permit = s_reg.permit;

    assign clock_ratio_high  = s_reg.cfg[RSCL_POS_RATIO];
    assign limp_mode         = s_reg.cfg[RSCL_POS_LIMP];
    assign osc_bypass        = s_reg.cfg[RSCL_POS_OSC_BYP];
    assign ref_freq_high     = s_reg.cfg[RSCL_POS_FREQ];
    assign boot_width        = boot_dec;
    assign high_drive        = s_reg.cfg[RSCL_POS_DRIVE];
    assign upper_chip_selects_en = s_reg.cfg[RSCL_POS_CS_SEL];

endmodule

/* rtl/rscl_pkg.sv */
// constants for the reset-time strap configuration latch
package rscl_pkg;

    // ==================================================
    // bus and pin widths
    localparam int RSCL_DATA_W      = 32;   // data bus pins and wishbone data
    localparam int RSCL_ADR_W       = 8;    // wishbone byte address width
    localparam int RSCL_CFG_W       = 10;   // strap field image, bits 9:0
    localparam int RSCL_STRAP_NUM   = 8;    // data lines that carry straps

    // ==================================================
    // strap field positions on the data bus
    localparam int RSCL_POS_RATIO   = 1;    // core/bus clock ratio
    localparam int RSCL_POS_OSC_BYP = 2;    // oscillator bypass
    localparam int RSCL_POS_BOOT_LO = 3;    // boot port width, low bit
    localparam int RSCL_POS_BOOT_HI = 4;    // boot port width, high bit
    localparam int RSCL_POS_DRIVE   = 5;    // output pad drive strength
    localparam int RSCL_POS_LIMP    = 6;    // limp mode
    localparam int RSCL_POS_FREQ    = 7;    // reference frequency select
    localparam int RSCL_POS_CS_SEL  = 9;    // upper pins as chip selects

    // mask of the eight data lines that carry straps (1..7 and 9)
    localparam logic [RSCL_CFG_W-1:0] RSCL_STRAP_MASK = 10'h2FE;

    // ==================================================
    // default field values, used when the override enable is negated
    localparam logic [RSCL_CFG_W-1:0] RSCL_CFG_DEFAULT = 10'h200;

    // ==================================================
    // boot port width encoding on the boot_width output
    localparam logic [1:0] RSCL_BW_32 = 2'h0;
    localparam logic [1:0] RSCL_BW_16 = 2'h1;
    localparam logic [1:0] RSCL_BW_8  = 2'h2;

    // ==================================================
    // timing
    localparam int RSCL_CLK_PERIOD_PS  = 4000;  // 250 MHz bus clock
    localparam int RSCL_RESET_OUTPUT_HOLD_NS = 1000;  // reset output low time
    // least time, rounded up to whole cycles
    localparam int RSCL_RESET_OUTPUT_HOLD_CYC =
        (RSCL_RESET_OUTPUT_HOLD_NS * 1000 + RSCL_CLK_PERIOD_PS - 1) / RSCL_CLK_PERIOD_PS;
    localparam int RSCL_PIN_TURN_CYC   = 1;     // bus clocks before pins may drive

    // ==================================================
    // register offsets (byte addresses)
    localparam logic [RSCL_ADR_W-1:0] RSCL_REG_CTRL   = 8'h00;
    localparam logic [RSCL_ADR_W-1:0] RSCL_REG_STATUS = 8'h04;
    localparam logic [RSCL_ADR_W-1:0] RSCL_REG_CONFIG = 8'h08;
    localparam logic [RSCL_ADR_W-1:0] RSCL_REG_RAW    = 8'h0C;

    // control register bits
    localparam int RSCL_CTRL_RESTART   = 0;     // write 1: rerun reset sequence
    localparam int RSCL_CTRL_FORCE_DEF = 1;     // next capture ignores pins

    // status register bits
    localparam int RSCL_ST_RST_OUT     = 0;     // reset output asserted
    localparam int RSCL_ST_PERMIT      = 1;     // data pins may be driven
    localparam int RSCL_ST_OVR_USED    = 2;     // last capture took pin values
    localparam int RSCL_ST_DRAM        = 3;     // memory select strap at capture
    localparam int RSCL_ST_CAP_DONE    = 4;     // sticky, write 1 to clear
    localparam int RSCL_ST_BOOT_LO     = 8;     // decoded boot width, 2 bits

endpackage

/* rtl/rscl_sync.sv */
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps

module rscl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ==================================================
    // state
    typedef struct packed {
        logic [WIDTH-1:0] meta;     // first stage, read only by second
        logic [WIDTH-1:0] stable;   // second stage, safe to use
    } rscl_sync_t;

    rscl_sync_t s_reg;              // registered state
    rscl_sync_t s_next;             // next state

    // ==================================================
    // next state: shift pins through both stages
    always_comb
    begin
        s_next        = s_reg;
        s_next.meta   = async_in;
        s_next.stable = s_reg.meta;
    end

    // register, synchronous active-low reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stable;

endmodule

/* tb/rscl_latch_sva.sv */
// assertion checker for the strap configuration latch
`timescale 1ns/1ps
module rscl_latch_sva
    import rscl_pkg::*;
#(
    parameter int HOLD_CYCLES = 8
) (
    input logic                               clk,
    input logic                               rst_b,
    input logic                               wb_cyc_i,
    input logic                               wb_stb_i,
    input logic                               wb_we_i,
    input logic [rscl_pkg::RSCL_ADR_W-1:0]    wb_adr_i,
    input logic [3:0]                         wb_sel_i,
    input logic [rscl_pkg::RSCL_DATA_W-1:0]   wb_dat_i,
    input logic                               wb_ack_o,
    input logic [rscl_pkg::RSCL_DATA_W-1:0]   data_pin_i,
    input logic                               strap_override_enable,
    input logic                               dynamic_memory_select_strap,
    input logic                               reset_output_b,
    input logic                               data_drive_permit,
    input logic                               clock_ratio_high,
    input logic                               osc_bypass,
    input logic [1:0]                         boot_width,
    input logic                               high_drive,
    input logic                               limp_mode,
    input logic                               ref_freq_high,
    input logic                               upper_chip_selects_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==================================================
    // helper state
    logic [11:0] dly1_reg, dly2_reg, dly3_reg; // memory strap, enable, pins 9:0
    logic        force_reg;                    // copy of the force-default bit
    int          lo_cnt_reg;                   // edges with reset output low
    logic [9:0]  exp_img;                      // expected config image
    logic [1:0]  bw_exp;                       // expected boot width

    // pin pipeline matching synchroniser and capture
    always_ff @(posedge clk)
    begin
        dly1_reg <= {dynamic_memory_select_strap, strap_override_enable, data_pin_i[9:0]};
        dly2_reg <= dly1_reg;
        dly3_reg <= dly2_reg;
    end

    // control writes and low-time count
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            force_reg  <= 1'b0;
            lo_cnt_reg <= 0;
        end
        else
        begin
            // write taken at the acknowledging edge
            if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                && wb_adr_i == RSCL_REG_CTRL)
                force_reg <= wb_dat_i[RSCL_CTRL_FORCE_DEF];
            lo_cnt_reg <= reset_output_b ? 0 : lo_cnt_reg + 1;
        end
    end

    // expected image: pins only with enable and no forced default
    assign exp_img = (dly3_reg[10] && !force_reg) ? (dly3_reg[9:0] & RSCL_STRAP_MASK)
                                                   : RSCL_CFG_DEFAULT;

    // boot width decode, 32-bit lost without memory strap
    always_comb
    begin
        case (exp_img[4:3])
            2'h1:    bw_exp = RSCL_BW_16;
            2'h2:    bw_exp = RSCL_BW_8;
            default: bw_exp = dly3_reg[11] ? RSCL_BW_32 : RSCL_BW_16;
        endcase
    end

    // ==================================================
    // sequences and properties
    sequence s_release; $rose(reset_output_b); endsequence
    sequence s_permit_on; ##1 $rose(data_drive_permit); endsequence

    property p_permit_rise; s_release |-> s_permit_on; endproperty
    a_permit_rise: assert property (p_permit_rise) else $error("permit late");
    property p_permit_safe; data_drive_permit |-> reset_output_b && $past(reset_output_b); endproperty
    a_permit_safe: assert property (p_permit_safe) else $error("permit early");
    property p_cfg_hold;
        !$rose(reset_output_b) |-> $stable({clock_ratio_high, osc_bypass, boot_width, high_drive,
                                           limp_mode, ref_freq_high, upper_chip_selects_en});
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
    property p_ratio_limp;
        s_release |-> clock_ratio_high == exp_img[1] && limp_mode == exp_img[6];
    endproperty
    a_ratio_limp: assert property (p_ratio_limp) else $error("ratio or limp wrong");
    property p_osc_freq;
        s_release |-> osc_bypass == exp_img[2] && ref_freq_high == exp_img[7];
    endproperty
    a_osc_freq: assert property (p_osc_freq) else $error("oscillator wrong");
    property p_drive; s_release |-> high_drive == exp_img[5]; endproperty
    a_drive: assert property (p_drive) else $error("drive wrong");
    property p_cs_sel; s_release |-> upper_chip_selects_en == exp_img[9]; endproperty
    a_cs_sel: assert property (p_cs_sel) else $error("chip select wrong");
    property p_boot; s_release |-> boot_width == bw_exp; endproperty
    a_boot: assert property (p_boot) else $error("boot width wrong");
    property p_hold_len; s_release |-> lo_cnt_reg >= HOLD_CYCLES - 1; endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset output too short");
endmodule

bind rscl_latch rscl_latch_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.*);

/* tb/rscl_strap_drv.sv */
// behavioural model of the board circuit that drives the reset straps
`timescale 1ns/1ps
module rscl_strap_drv (
    input  wire logic        clk,
    input  wire logic        reset_output_b,
    input  wire logic        slow,
    input  wire logic [31:0] strap_val,
    output logic      [31:0] data_pin
);
    logic late_reg; // first low edge skipped when slow

    always @(posedge clk)
    begin
        if (reset_output_b === 1'b0)
        begin
            late_reg <= 1'b1;
            if (!slow || late_reg)
                data_pin <= strap_val;
        end
        else
        begin
            // released lines wander, never keep the strap
            late_reg <= 1'b0;
            data_pin <= ~data_pin;
        end
    end
endmodule

/* tb/rscl_latch_tb.sv */
// self-checking bench for the strap configuration latch
`timescale 1ns/1ps
module rscl_latch_tb;
    import rscl_pkg::*;

    // ==================================================
    // signals
    logic        clk, rst_b;                       // clock and sync reset
    logic        wb_cyc, wb_stb, wb_we, wb_ack;    // wishbone handshake
    logic [7:0]  wb_adr;                           // byte address
    logic [3:0]  wb_sel;                           // byte enables
    logic [31:0] wb_dat_w, wb_dat_r;               // write and read data
    logic [31:0] data_pin, strap_val;              // pins and board strap value
    logic        strap_en, dram_strap, force_def, slow; // board settings
    logic        rout_b, permit, ratio, osc, drive, limp, freq, ucs; // latch outputs
    logic [1:0]  bw;                               // decoded boot width
    int          seed = 2226;                      // fixed seed
    int          fail_count = 0;                   // mismatches
    int          n_tests = 0;                      // comparisons

    rscl_latch #(.HOLD_CYCLES(8)) dut (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .data_pin_i(data_pin), .strap_override_enable(strap_en),
        .dynamic_memory_select_strap(dram_strap), .reset_output_b(rout_b),
        .data_drive_permit(permit), .clock_ratio_high(ratio), .osc_bypass(osc),
        .boot_width(bw), .high_drive(drive), .limp_mode(limp), .ref_freq_high(freq),
        .upper_chip_selects_en(ucs)
    );

    rscl_strap_drv u_board (
        .clk(clk), .reset_output_b(rout_b), .slow(slow), .strap_val(strap_val),
        .data_pin(data_pin)
    );

    // ==================================================
    // expectations and checks
    function automatic logic [9:0] exp_img(input logic [9:0] p, input logic use_p);
        return use_p ? (p & RSCL_STRAP_MASK) : RSCL_CFG_DEFAULT;
    endfunction

    function automatic logic [1:0] exp_bw(input logic [1:0] code, input logic dram);
        logic [1:0] w;
        w = (code == 2'h1) ? RSCL_BW_16 : (code == 2'h2) ? RSCL_BW_8 : RSCL_BW_32;
        return (!dram && w == RSCL_BW_32) ? RSCL_BW_16 : w;
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled
    task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                           output logic [31:0] q);
        int n = 0;
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= w;
        wb_adr   <= a;
        wb_sel   <= 4'hF;
        wb_dat_w <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20)
            fail_count++;
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk);
    endtask

    // bounded wait for a permit level
    task automatic wait_permit(input logic v);
        int n = 0;
        while (permit !== v && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 80)
            fail_count++;
    endtask

    // outputs and registers after a capture
    task automatic check_cap();
        logic        use_p;
        logic [9:0]  img;
        logic [1:0]  bw_e;
        logic [31:0] q;
        use_p = strap_en & ~force_def;
        img   = exp_img(strap_val[9:0], use_p);
        bw_e  = exp_bw(img[4:3], dram_strap);
        chk_out({ucs, freq, limp, drive, osc, ratio, bw},
                {img[9], img[7:5], img[2:1], bw_e});
        wb_xfer(RSCL_REG_CONFIG, 1'b0, 32'h0, q);
        chk_word(q, {22'h0, img});
        wb_xfer(RSCL_REG_STATUS, 1'b0, 32'h0, q);
        chk_word(q, {22'h0, bw_e, 4'h1, dram_strap, use_p, 2'h2});
        wb_xfer(RSCL_REG_STATUS, 1'b1, 32'h10, q);
        wb_xfer(RSCL_REG_STATUS, 1'b0, 32'h0, q);
        chk_word(q, {22'h0, bw_e, 4'h0, dram_strap, use_p, 2'h2});
        wb_xfer(RSCL_REG_CTRL, 1'b0, 32'h0, q);
        chk_word(q, {30'h0, force_def, 1'b0});
        // unmapped place reads zero
        wb_xfer(8'h10, 1'b0, 32'h0, q);
        chk_word(q, 32'h0);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================
    // clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #100000;
        fail_count++;
        final_report();
    end

    initial
    begin
        logic [31:0] r, v, q;
        rst_b = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h0;
        wb_sel = 4'h0; wb_dat_w = 32'h0; strap_en = 1'b0; dram_strap = 1'b1;
        force_def = 1'b0; slow = 1'b0; strap_val = $random(seed);
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        wait_permit(1'b1);
        check_cap();
        $display("test power-on defaults done");
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            v = $random(seed);
            // corners: boot codes by memory strap, then defaults
            if (i < 8)
            begin
                v[4:3] = i[1:0];
                r[2:0] = {i[2], 2'b10};
            end
            else if (i < 10)
            begin
                v      = 32'hFFFFFFFF;
                r[2:0] = {1'b1, i[0], i[0]};
            end
            strap_val  <= v;
            strap_en   <= r[1];
            dram_strap <= r[2];
            force_def  <= r[0];
            slow       <= r[3];
            wb_xfer(RSCL_REG_CTRL, 1'b1, {30'h0, r[0], 1'b1}, q);
            wait_permit(1'b0);
            wait_permit(1'b1);
            check_cap();
            $display("test %0d done", i);
        end
        final_report();
    end
endmodule
